// File: nsu_pkg.sv
// Package: constants and types of the negative-sequence unbalance trip element
package nsu_pkg;

    // Widths
    localparam int unsigned CUR_W = 16;
    localparam int unsigned ANG_W = 16;
    localparam int unsigned PCT_W = 8;
    localparam int unsigned TIME_W = 32;
    // Wide enough for the largest capability setting shifted into energy units
    localparam int unsigned ENERGY_W = 64;

    // Clock and sample timing
    localparam int unsigned CLK_HZ = 125_000_000;
    localparam int unsigned TICK_US = 1000;
    localparam int unsigned TICK_CYCLES = (CLK_HZ / 1_000_000) * TICK_US;
    localparam int unsigned TICK_W = 20;

    // Current scaling: nominal current equals this code
    localparam int unsigned NOM_CODE = 4096;

    // Drop-out figures
    localparam int unsigned DROPOUT_NUM = 97;
    localparam int unsigned DROPOUT_DEN = 100;
    localparam logic [PCT_W-1:0] RATIO_HYST_PCT = 8'h01;
    localparam int unsigned COOL_END_DIV = 100;

    // Reset values
    localparam logic [ENERGY_W-1:0] ENERGY_RST = 64'h0000_0000_0000_0000;
    localparam logic [TIME_W-1:0] TIMER_RST = 32'h0000_0000;

    typedef enum logic {
        NSU_CHAR_DEFINITE,
        NSU_CHAR_INVERSE
    } nsu_char_t;

    typedef enum logic [1:0] {
        NSU_ST_IDLE,
        NSU_ST_HEAT,
        NSU_ST_COOL
    } nsu_phase_t;

endpackage

// File: nsu_seq_calc.sv
// Symmetrical component extraction: positive and negative sequence magnitudes
`timescale 1ns/100ps
module nsu_seq_calc
    import nsu_pkg::*;
(
    // Clock and reset
    input wire logic i_clk,
    input wire logic i_reset,
    // Phasors
    input wire logic i_valid,
    input wire logic signed [CUR_W-1:0] i_re [3],
    input wire logic signed [CUR_W-1:0] i_im [3],
    input wire logic i_rot_acb,
    // Magnitudes
    output logic o_valid,
    output logic [CUR_W-1:0] o_pos,
    output logic [CUR_W-1:0] o_neg
);
    // cos(120) = -0.5, sin(120) = 0.866 in Q15
    localparam logic signed [17:0] SIN120 = 18'sh0_6EDA;

    typedef struct packed {
        logic vld;
        logic [CUR_W-1:0] pos;
        logic [CUR_W-1:0] neg;
    } nsu_seq_st_t;

    nsu_seq_st_t st_q;
    nsu_seq_st_t st_d;

    // Rotate phasor by +120 (dir=1) or -120 degrees, scaled by 2
    function automatic void rot(input logic signed [CUR_W+1:0] re, input logic signed [CUR_W+1:0] im,
                                input logic dir, output logic signed [CUR_W+3:0] ore,
                                output logic signed [CUR_W+3:0] oim);
        logic signed [CUR_W+19:0] s_re;
        logic signed [CUR_W+19:0] s_im;
        s_re = re * SIN120;
        s_im = im * SIN120;
        if (dir) begin
            ore = 20'(-re - (s_im >>> 14));
            oim = 20'(-im + (s_re >>> 14));
        end else begin
            ore = 20'(-re + (s_im >>> 14));
            oim = 20'(-im - (s_re >>> 14));
        end
    endfunction

    function automatic logic [CUR_W-1:0] mag(input logic signed [CUR_W+3:0] re,
                                             input logic signed [CUR_W+3:0] im);
        logic [CUR_W+3:0] a;
        logic [CUR_W+3:0] b;
        logic [CUR_W+4:0] m;
        a = re[CUR_W+3] ? 20'(-re) : 20'(re);
        b = im[CUR_W+3] ? 20'(-im) : 20'(im);
        // Alpha-max plus beta-min, within about 7 percent
        m = (a > b) ? (21'(a) + 21'(b >> 2) + 21'(b >> 3)) : (21'(b) + 21'(a >> 2) + 21'(a >> 3));
        m = m / 21'd6;
        mag = (m > 21'(16'hFFFF)) ? 16'hFFFF : m[CUR_W-1:0];
    endfunction

    always_comb begin
        logic signed [CUR_W+3:0] br_re;
        logic signed [CUR_W+3:0] br_im;
        logic signed [CUR_W+3:0] cr_re;
        logic signed [CUR_W+3:0] cr_im;
        logic signed [CUR_W+3:0] bs_re;
        logic signed [CUR_W+3:0] bs_im;
        logic signed [CUR_W+3:0] cs_re;
        logic signed [CUR_W+3:0] cs_im;
        logic [CUR_W-1:0] m1;
        logic [CUR_W-1:0] m2;
        m1 = '0;
        m2 = '0;
        br_re = '0;
        br_im = '0;
        cr_re = '0;
        cr_im = '0;
        bs_re = '0;
        bs_im = '0;
        cs_re = '0;
        cs_im = '0;
        st_d = st_q;
        // I1 = (a + a*b + a^2*c)/3, I2 = (a + a^2*b + a*c)/3
        rot(18'(i_re[1]), 18'(i_im[1]), 1'b1, br_re, br_im);
        rot(18'(i_re[2]), 18'(i_im[2]), 1'b0, cr_re, cr_im);
        rot(18'(i_re[1]), 18'(i_im[1]), 1'b0, bs_re, bs_im);
        rot(18'(i_re[2]), 18'(i_im[2]), 1'b1, cs_re, cs_im);
        m1 = mag(20'(i_re[0]) * 20'sd2 + br_re + cr_re, 20'(i_im[0]) * 20'sd2 + br_im + cr_im);
        m2 = mag(20'(i_re[0]) * 20'sd2 + bs_re + cs_re, 20'(i_im[0]) * 20'sd2 + bs_im + cs_im);
        st_d.vld = i_valid;
        if (i_valid) begin
            // Reverse rotation swaps the two sequences
            st_d.pos = i_rot_acb ? m2 : m1;
            st_d.neg = i_rot_acb ? m1 : m2;
        end
    end

    always_ff @(posedge i_clk or posedge i_reset) begin
        if (i_reset) begin
            st_q <= '0;
        end else begin
            st_q <= st_d;
        end
    end

    assign o_valid = st_q.vld;
    assign o_pos = st_q.pos;
    assign o_neg = st_q.neg;
endmodule

// File: nsu_trip.sv
// Negative-sequence unbalance trip element with definite and inverse characteristics
// Function
// - Derive I1, I2 honouring phase rotation
// - I2 must exceed threshold to operate
// - Optional ratio pickup on UNBALANCE_RATIO_PICKUP percent
// - Trip when conditions hold for delay
// - Threshold held in nominal-current units
// - Definite time uses delay setting
// - Inverse time computes its own delay
// - Thermal energy updated always
// - Inverse trip also needs energy above max
// - Zero-heat delay K over I2^2 minus threshold^2
// - Residual heat shortens inverse delay
// - Heating integrates squared I2 above threshold
// - Heating starts from cooling residue or zero
// - Cooling decays energy with tau-cool
// - Below one hundredth of max, clear energy
// - Protection reset clears function and timers
// - All instances identical in structure
// - Threshold drops out at 0.97 of setting
// - Ratio drops out one point below setting
`timescale 1ns/100ps
module nsu_trip
    import nsu_pkg::*;
#(
    parameter int unsigned TICK_CYC = TICK_CYCLES
)(
    // Clock and reset
    input wire logic i_clk,
    input wire logic i_reset,
    // Phase phasors, NOM_CODE is one nominal current
    input wire logic i_sample_valid,
    input wire logic signed [nsu_pkg::CUR_W-1:0] i_phase_re [3],
    input wire logic signed [nsu_pkg::CUR_W-1:0] i_phase_im [3],
    // Settings
    input wire logic i_enable,
    input wire logic i_phase_rotation_acb,
    input wire logic [nsu_pkg::CUR_W-1:0] i_neg_seq_threshold,
    input wire logic i_ratio_check_enable,
    input wire logic [nsu_pkg::PCT_W-1:0] i_unbalance_ratio_pickup,
    input wire logic i_inverse_time_mode,
    input wire logic [nsu_pkg::TIME_W-1:0] i_definite_delay_ms,
    input wire logic [nsu_pkg::TIME_W-1:0] i_capability_k_ms,
    input wire logic [nsu_pkg::TIME_W-1:0] i_tau_cool_ms,
    // Operator command
    input wire logic i_prot_reset,
    // Status
    output logic o_pickup,
    output logic o_trip,
    output logic o_heating,
    output logic [nsu_pkg::CUR_W-1:0] o_neg_seq,
    output logic [nsu_pkg::CUR_W-1:0] o_pos_seq
);
    import nsu_pkg::*;

    localparam int unsigned SQ_SHIFT = 24;

    typedef struct packed {
        logic [TICK_W-1:0] div;
        logic tick;
        logic thr_ok;
        logic ratio_ok;
        logic pickup;
        logic trip;
        logic heating;
        nsu_phase_t phase;
        logic [TIME_W-1:0] timer;
        logic [ENERGY_W-1:0] energy;
        logic [CUR_W-1:0] neg;
        logic [CUR_W-1:0] pos;
    } nsu_state_t;

    nsu_state_t st_q;
    nsu_state_t st_d;

    logic seq_valid;
    logic [CUR_W-1:0] seq_pos;
    logic [CUR_W-1:0] seq_neg;

    // -----------------------------------------------------------------
    // Sequence extraction
    // -----------------------------------------------------------------
    nsu_seq_calc nsu_seq_calc_i (
        .i_clk(i_clk),
        .i_reset(i_reset),
        .i_valid(i_sample_valid),
        .i_re(i_phase_re),
        .i_im(i_phase_im),
        .i_rot_acb(i_phase_rotation_acb),
        .o_valid(seq_valid),
        .o_pos(seq_pos),
        .o_neg(seq_neg)
    );

    // -----------------------------------------------------------------
    // Element logic
    // -----------------------------------------------------------------
    always_comb begin
        logic [31:0] neg_sq;
        logic [31:0] thr_sq;
        logic [ENERGY_W-1:0] e_max;
        logic [ENERGY_W+TIME_W-1:0] decay;
        logic [CUR_W+7:0] neg_pct;
        logic [CUR_W+7:0] pick_lvl;
        logic [CUR_W+7:0] drop_lvl;
        logic [CUR_W+7:0] neg_x100;
        logic [CUR_W+7:0] thr_drop;
        logic hot;
        logic operate;
        st_d = st_q;
        st_d.tick = 1'b0;
        neg_sq = 32'(st_q.neg) * 32'(st_q.neg);
        thr_sq = 32'(i_neg_seq_threshold) * 32'(i_neg_seq_threshold);
        // Energy in (pu^2 * ms) units; max equals K at full unbalance
        e_max = ENERGY_W'(i_capability_k_ms) << SQ_SHIFT;
        decay = '0;
        operate = 1'b0;
        // Ratio compare scaled by 100 to avoid a divider
        neg_pct = 24'(st_q.neg) * 24'd100;
        pick_lvl = 24'(st_q.pos) * 24'(i_unbalance_ratio_pickup);
        drop_lvl = (i_unbalance_ratio_pickup > RATIO_HYST_PCT)
                 ? 24'(st_q.pos) * 24'(i_unbalance_ratio_pickup - RATIO_HYST_PCT) : '0;
        neg_x100 = 24'(st_q.neg) * 24'(DROPOUT_DEN);
        thr_drop = 24'(i_neg_seq_threshold) * 24'(DROPOUT_NUM);
        hot = st_q.neg > i_neg_seq_threshold;

        if (seq_valid) begin
            st_d.neg = seq_neg;
            st_d.pos = seq_pos;
        end

        // Millisecond tick divider
        if (st_q.div >= TICK_W'(TICK_CYC - 1)) begin
            st_d.div = '0;
            st_d.tick = 1'b1;
        end else begin
            st_d.div = st_q.div + 1'b1;
        end

        // Threshold in nominal units, with drop-out hysteresis
        if (hot) begin
            st_d.thr_ok = 1'b1;
        end else if (neg_x100 <= thr_drop) begin
            st_d.thr_ok = 1'b0;
        end
        if (neg_pct > pick_lvl) begin
            st_d.ratio_ok = 1'b1;
        end else if (neg_pct < drop_lvl || neg_pct == drop_lvl) begin
            st_d.ratio_ok = 1'b0;
        end
        operate = i_enable && st_q.thr_ok && (!i_ratio_check_enable || st_q.ratio_ok);
        st_d.pickup = operate;

        // Thermal model runs each tick regardless of trip state
        if (st_q.tick) begin
            if (hot) begin
                // Integral of (I2^2 - thr^2) gives K/(I2^2 - thr^2) from zero
                // and starts from residue, so shortens delay
                st_d.phase = NSU_ST_HEAT;
                if (st_q.energy <= e_max) begin
                    st_d.energy = st_q.energy + ENERGY_W'((neg_sq - thr_sq) >> (32 - SQ_SHIFT - 8));
                end
            end else if (st_q.energy != ENERGY_RST) begin
                st_d.phase = NSU_ST_COOL;
                // e *= (1 - 1/tau), one-ms step
                decay = (i_tau_cool_ms == '0) ? (ENERGY_W+TIME_W)'(st_q.energy)
                      : (ENERGY_W+TIME_W)'(st_q.energy / ENERGY_W'(i_tau_cool_ms));
                st_d.energy = st_q.energy - ((decay == '0) ? ENERGY_W'(1) : decay[ENERGY_W-1:0]);
                if (st_d.energy < e_max / ENERGY_W'(COOL_END_DIV)) begin
                    st_d.energy = ENERGY_RST;
                    st_d.phase = NSU_ST_IDLE;
                end
            end else begin
                st_d.phase = NSU_ST_IDLE;
            end
        end

        // Trip timing
        if (!operate) begin
            st_d.timer = TIMER_RST;
            st_d.trip = 1'b0;
        end else if (!i_inverse_time_mode) begin
            if (st_q.tick && st_q.timer < i_definite_delay_ms) begin
                st_d.timer = st_q.timer + 1'b1;
            end
            st_d.trip = (st_q.timer >= i_definite_delay_ms);
        end else begin
            st_d.timer = TIMER_RST;
            st_d.trip = (st_q.energy > e_max);
        end

        if (i_prot_reset) begin
            st_d.timer = TIMER_RST;
            st_d.energy = ENERGY_RST;
            st_d.trip = 1'b0;
            st_d.pickup = 1'b0;
            st_d.thr_ok = 1'b0;
            st_d.ratio_ok = 1'b0;
            st_d.phase = NSU_ST_IDLE;
        end
        // Registered copy so the output comes straight from a flop
        st_d.heating = (st_d.phase == NSU_ST_HEAT);
    end

    always_ff @(posedge i_clk or posedge i_reset) begin
        if (i_reset) begin
            st_q <= '0;
            st_q.phase <= NSU_ST_IDLE;
        end else begin
            st_q <= st_d;
        end
    end

    // -----------------------------------------------------------------
    // Outputs
    // -----------------------------------------------------------------
    assign o_pickup = st_q.pickup;
    assign o_trip = st_q.trip;
    assign o_heating = st_q.heating;
    assign o_neg_seq = st_q.neg;
    assign o_pos_seq = st_q.pos;
endmodule

// File: nsu_trip_sva.sv
// Checker: port-level assertions of the unbalance trip element
`timescale 1ns/100ps
module nsu_trip_sva
    import nsu_pkg::*;
#(
    parameter int unsigned TICK_CYC = TICK_CYCLES
)(
    // Clock, reset, settings
    input wire logic i_clk,
    input wire logic i_reset,
    input wire logic i_enable,
    input wire logic [nsu_pkg::CUR_W-1:0] i_neg_seq_threshold,
    input wire logic i_inverse_time_mode,
    input wire logic [nsu_pkg::TIME_W-1:0] i_definite_delay_ms,
    input wire logic i_prot_reset,
    // Status
    input wire logic o_pickup,
    input wire logic o_trip,
    input wire logic o_heating,
    input wire logic [nsu_pkg::CUR_W-1:0] o_neg_seq
);
    logic [31:0] pu_cnt_q;
    logic [31:0] hot_cnt_q;
    logic [31:0] cold_cnt_q;
    logic above;
    logic cold;
    assign above = (o_neg_seq > i_neg_seq_threshold) && !i_prot_reset;
    assign cold = (o_neg_seq <= i_neg_seq_threshold) && !i_prot_reset;
    // ----------------
    // Thermal run lengths
    // ----------------
    // Heating only follows a tick, so it is judged after a whole tick period
    always_ff @(posedge i_clk or posedge i_reset) begin
        if (i_reset) begin
            hot_cnt_q <= 32'h0000_0000;
            cold_cnt_q <= 32'h0000_0000;
        end else begin
            if (!above)
                hot_cnt_q <= 32'h0000_0000;
            else if (hot_cnt_q != 32'hffff_ffff)
                hot_cnt_q <= hot_cnt_q + 32'h0000_0001;
            if (!cold)
                cold_cnt_q <= 32'h0000_0000;
            else if (cold_cnt_q != 32'hffff_ffff)
                cold_cnt_q <= cold_cnt_q + 32'h0000_0001;
        end
    end
    // ----------------
    // Pickup run length
    // ----------------
    // Saturates so a long hold never wraps into a false early trip
    always_ff @(posedge i_clk or posedge i_reset) begin
        if (i_reset)
            pu_cnt_q <= 32'h0000_0000;
        else if (!o_pickup || i_prot_reset)
            pu_cnt_q <= 32'h0000_0000;
        else if (pu_cnt_q != 32'hffff_ffff)
            pu_cnt_q <= pu_cnt_q + 32'h0000_0001;
    end
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (i_reset);
    sequence s_hot;
        hot_cnt_q >= TICK_CYC;
    endsequence
    sequence s_cold;
        cold_cnt_q >= TICK_CYC;
    endsequence
    // ----------------
    // Properties
    // ----------------
    a_quiet_after_reset: assert property ($fell(i_reset) |-> !o_trip && !o_pickup && !o_heating)
        else $error("outputs not clear after reset");
    a_trip_has_pickup: assert property ($rose(o_trip) |-> o_pickup || $past(o_pickup))
        else $error("trip without pickup");
    a_prot_clears_trip: assert property (i_prot_reset |=> !o_trip)
        else $error("trip survives protection reset");
    a_disabled_quiet: assert property (!i_enable [*4] |-> !o_pickup && !o_trip)
        else $error("activity while disabled");
    a_heat_when_above: assert property (s_hot |-> o_heating)
        else $error("not heating above threshold");
    a_cool_at_equal: assert property (s_cold |-> !o_heating)
        else $error("heating at or below threshold");
    a_pickup_cause: assert property ($rose(o_pickup) |-> $past(above) || $past(above, 2) || $past(above, 3))
        else $error("pickup below threshold");
    a_definite_time_mode_not_early: assert property ($rose(o_trip) && !i_inverse_time_mode |->
        pu_cnt_q + TICK_CYC >= i_definite_delay_ms * TICK_CYC)
        else $error("definite trip too early");
    a_definite_time_mode_not_late: assert property (!i_inverse_time_mode && o_pickup &&
        pu_cnt_q > (i_definite_delay_ms + 2) * TICK_CYC |-> o_trip)
        else $error("definite trip missing");
    a_inv_above_level: assert property ($rose(o_trip) && i_inverse_time_mode |->
        $past(o_neg_seq, 2) * 100 > $past(i_neg_seq_threshold, 2) * 97)
        else $error("inverse trip below threshold level");
endmodule

// File: nsu_trip_bench.sv
// Testbench: directed checks of the unbalance trip element
`timescale 1ns/100ps
module nsu_trip_bench;
    import nsu_pkg::*;
    localparam int unsigned TK = 10;
    logic clk = 1'b0, rst = 1'b1, sv = 1'b1, en = 1'b1, rot = 1'b0, ren = 1'b0, inverse_time_mode = 1'b0, prst = 1'b0;
    logic [CUR_W-1:0] thr = 16'h0800;
    logic [PCT_W-1:0] rpk = 8'h32;
    logic [TIME_W-1:0] dly = 32'h0000_0005, kk = 32'h0000_0003, tau = 32'h0000_03e8;
    logic signed [CUR_W-1:0] re [3];
    logic signed [CUR_W-1:0] im [3];
    logic pu, trp, heat;
    logic [CUR_W-1:0] neg, pos;
    int mismatches = 0, cmp_count = 0, cyc = 0, n;
    nsu_trip #(.TICK_CYC(TK)) nsu_trip_i (.i_clk(clk), .i_reset(rst), .i_sample_valid(sv), .i_phase_re(re),
        .i_phase_im(im), .i_enable(en), .i_phase_rotation_acb(rot), .i_neg_seq_threshold(thr),
        .i_ratio_check_enable(ren), .i_unbalance_ratio_pickup(rpk), .i_inverse_time_mode(inverse_time_mode),
        .i_definite_delay_ms(dly), .i_capability_k_ms(kk), .i_tau_cool_ms(tau), .i_prot_reset(prst),
        .o_pickup(pu), .o_trip(trp), .o_heating(heat), .o_neg_seq(neg), .o_pos_seq(pos));
    // ----------------
    // Tasks
    // ----------------
    task complete_run();
        if (mismatches == 0 && cmp_count > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    task chk(input logic ok, input string m);
        cmp_count++;
        if (ok !== 1'b1) begin
            mismatches++;
            $display("CHECK FAILED %0t %s", $time, m);
        end
    endtask
    // Phase amplitudes at 0, -120 and +120 degrees
    task ph(input int a, input int b, input int c);
        @(negedge clk);
        re[0] = CUR_W'(a);
        im[0] = '0;
        re[1] = CUR_W'(-b / 2);
        im[1] = CUR_W'(-(b * 887) / 1024);
        re[2] = CUR_W'(-c / 2);
        im[2] = CUR_W'((c * 887) / 1024);
    endtask
    task wt(input int k);
        repeat (k) @(negedge clk);
    endtask
    // Bounded wait for pickup (w = 0) or trip (w = 1)
    task wait_for(input bit w, output int t);
        t = 0;
        while (((w ? trp : pu) !== 1'b1) && t < 3000) begin
            @(negedge clk);
            t++;
        end
    endtask
    task pulse_reset();
        @(negedge clk) prst = 1'b1;
        wt(2);
        chk(trp === 1'b0, "trip held through reset");
        prst = 1'b0;
    endtask
    // ----------------
    // Clock and timeout
    // ----------------
    initial forever #4 clk = ~clk;
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            mismatches++;
            complete_run();
        end
    end
    // ----------------
    // Sequence
    // ----------------
    initial begin
        foreach (re[k]) begin
            re[k] = '0;
            im[k] = '0;
        end
        repeat (10) @(posedge clk);
        @(negedge clk) rst = 1'b0;
        chk(pu === 1'b0 && trp === 1'b0 && heat === 1'b0 && neg === '0 && pos === '0, "reset values");
        // Magnitudes carry up to about seven percent approximation error
        ph(4096, 4096, 4096);
        wt(6);
        chk(neg < 16'd200 && pos > 16'd3900 && pos < 16'd4300, "balanced");
        rot = 1'b1;
        wt(6);
        chk(neg > 16'd3900 && neg < 16'd4300 && pos < 16'd200, "reverse rotation");
        rot = 1'b0;
        ph(6144, 0, 0);
        wt(6);
        chk(neg > 16'd1950 && neg < 16'd2150 && pos > 16'd1950 && pos < 16'd2150, "single phase");
        ph(4915, 0, 0);
        wt(8);
        chk(pu === 1'b0 && heat === 1'b0, "below threshold");
        ph(7373, 0, 0);
        wait_for(0, n);
        chk(n < 8, "pickup above threshold");
        wait_for(1, n);
        chk(n >= 40 && n <= 62, "definite delay");
        chk(heat === 1'b1, "heating above threshold");
        wt(30);
        pulse_reset();
        wait_for(1, n);
        chk(n >= 38 && n <= 64, "retrip after reset");
        thr = 16'h0200;
        ren = 1'b1;
        ph(8192, 4096, 4096);
        pulse_reset();
        wt(10);
        chk(pu === 1'b0, "ratio below pickup");
        ph(8192, 0, 0);
        wait_for(0, n);
        chk(n < 8, "ratio above pickup");
        ren = 1'b0;
        ph(8192, 4096, 4096);
        wt(8);
        chk(pu === 1'b1, "ratio check off");
        thr = 16'h0800;
        ph(4096, 4096, 4096);
        pulse_reset();
        inverse_time_mode = 1'b1;
        ph(12288, 0, 0);
        wait_for(1, n);
        chk(n >= 28 && n <= 64, "inverse zero heat delay");
        ph(4096, 4096, 4096);
        wt(20);
        ph(12288, 0, 0);
        wait_for(1, n);
        chk(n <= 14, "residual heat shortens delay");
        tau = 32'h0000_0001;
        ph(4096, 4096, 4096);
        wt(400);
        ph(12288, 0, 0);
        wait_for(1, n);
        chk(n >= 28 && n <= 64, "energy cleared after cooling");
        en = 1'b0;
        wt(6);
        chk(pu === 1'b0 && trp === 1'b0, "disabled");
        complete_run();
    end
endmodule
bind nsu_trip nsu_trip_sva #(.TICK_CYC(TICK_CYC)) nsu_trip_sva_i (.i_clk(i_clk), .i_reset(i_reset),
    .i_enable(i_enable), .i_neg_seq_threshold(i_neg_seq_threshold), .i_inverse_time_mode(i_inverse_time_mode),
    .i_definite_delay_ms(i_definite_delay_ms), .i_prot_reset(i_prot_reset), .o_pickup(o_pickup),
    .o_trip(o_trip), .o_heating(o_heating), .o_neg_seq(o_neg_seq));
